// >>> src/lpinit_top.v
`timescale 1ns/100ps
`include "lpinit_regs.vh"
module lpinit_top #(
  parameter LANES = 2,
  parameter MODE_W = 14
) (
  input wire clk,
  input wire reset_n,
  input wire mem_clk,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bank_select,
  input wire [MODE_W-1:0] addr,
  input wire rd_drive,
  input wire wr_cap,
  input wire [8*LANES-1:0] rd_data,
  input wire [LANES-1:0] byte_lane_strobes_in,
  input wire [8*LANES-1:0] dq_in,
  output wire [LANES-1:0] byte_lane_strobes_out,
  output wire [LANES-1:0] byte_lane_strobes_oe_n,
  output wire [8*LANES-1:0] dq_out,
  output wire [8*LANES-1:0] wr_data,
  output wire [LANES-1:0] wr_valid,
  output reg [MODE_W-1:0] base_mode_q,
  output reg [MODE_W-1:0] ext_mode_q,
  output reg ready_q,
  output reg seq_error_q,
  output reg cmd_accept_q
);
  reg mck_s1_q;
  reg mck_s2_q;
  reg mck_s3_q;
  reg [7:0] ctl_s1_q;
  reg [7:0] ctl_s2_q;
  reg [MODE_W-1:0] a_s1_q;
  reg [MODE_W-1:0] a_s2_q;
  reg [2:0] state_q;
  reg [1:0] refr_q;
  reg base_ok_q;
  reg ext_ok_q;
  wire mck_rise;
  wire [3:0] cmd;
  wire cke_s;
  wire [1:0] ba_s;
  wire cmd_valid;
  wire ba_base;
  wire ba_ext;
  reg [2:0] state_d;
  assign mck_rise = mck_s2_q && !mck_s3_q;
  assign cmd = ctl_s2_q[3:0];
  assign cke_s = ctl_s2_q[4];
  assign ba_s = ctl_s2_q[6:5];
  // Deselect is dropped here so nothing below can act on it
  assign cmd_valid = mck_rise && !cs_sel_high(cmd);
  // Bank select picks which of the two mode registers a load writes
  assign ba_base = (ba_s == `LPINIT_BA_BASE);
  assign ba_ext = (ba_s == `LPINIT_BA_EXT);

  // Pins pass two flops before the decoder looks at them
  // A third flop on the clock gives the edge without reading the first stage
  always @(posedge clk) begin
    if (!reset_n) begin
      mck_s1_q <= 1'b0;
      mck_s2_q <= 1'b0;
      mck_s3_q <= 1'b0;
      ctl_s1_q <= 8'h00;
      ctl_s2_q <= 8'h00;
      a_s1_q <= {MODE_W{1'b0}};
      a_s2_q <= {MODE_W{1'b0}};
    end else begin
      mck_s1_q <= mem_clk;
      mck_s2_q <= mck_s1_q;
      mck_s3_q <= mck_s2_q;
      ctl_s1_q <= {1'b0, bank_select, cke, cs_n, ras_n, cas_n, we_n};
      ctl_s2_q <= ctl_s1_q;
      a_s1_q <= addr;
      a_s2_q <= a_s1_q;
    end
  end

  // Next init step; each step waits only for its own event
  always @* begin
    state_d = state_q;
    case (state_q)
      `LPINIT_ST_POWER: begin
        if (cke_s) begin
          state_d = `LPINIT_ST_STABLE;
        end
      end
      `LPINIT_ST_STABLE: begin
        if (cmd_valid && cmd == `LPINIT_CMD_PRECH) begin
          state_d = `LPINIT_ST_PRECH;
        end
      end
      `LPINIT_ST_PRECH: begin
        // Loads and refreshes may come in any order after close-all-banks
        if (base_ok_q && ext_ok_q && refr_q == `LPINIT_REF_NEEDED) begin
          state_d = `LPINIT_ST_READY;
        end
      end
      `LPINIT_ST_READY: begin
        // Only reset leaves ready; a power loss is seen as a reset
        state_d = `LPINIT_ST_READY;
      end
      default: begin
        state_d = `LPINIT_ST_POWER;
      end
    endcase
  end

  // Command decode at each memory clock rising crossing
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q <= `LPINIT_ST_POWER;
      refr_q <= 2'h0;
      base_ok_q <= 1'b0;
      ext_ok_q <= 1'b0;
      base_mode_q <= {MODE_W{1'b0}};
      ext_mode_q <= {MODE_W{1'b0}};
      ready_q <= 1'b0;
      seq_error_q <= 1'b0;
      cmd_accept_q <= 1'b0;
    end else begin
      cmd_accept_q <= 1'b0;
      // Timing waits are the controller's job; only order is tracked here
      if (cmd_valid) begin
        cmd_accept_q <= 1'b1;
        case (cmd)
          `LPINIT_CMD_PRECH: begin
            // Step change is made by the next-step logic
          end
          `LPINIT_CMD_REFR: begin
            if (state_q == `LPINIT_ST_STABLE) begin
              seq_error_q <= 1'b1;
            end else if (!ready_q && refr_q != `LPINIT_REF_NEEDED) begin
              refr_q <= refr_q + 2'h1;
            end
          end
          `LPINIT_CMD_MRS: begin
            if (ba_base) begin
              base_mode_q <= a_s2_q;
              base_ok_q <= 1'b1;
            end else if (ba_ext) begin
              ext_mode_q <= a_s2_q;
              ext_ok_q <= 1'b1;
            end
            if (state_q == `LPINIT_ST_STABLE) begin
              seq_error_q <= 1'b1;
            end
          end
          `LPINIT_CMD_NOP: begin
          end
          default: begin
            if (!ready_q) begin
              seq_error_q <= 1'b1;
            end
          end
        endcase
      end
      state_q <= state_d;
      // Ready is a registered copy of the last step so it never glitches
      if (state_d == `LPINIT_ST_READY) begin
        ready_q <= 1'b1;
      end
    end
  end

  // Chip select is the top bit of the command code
  function cs_sel_high;
    input [3:0] c;
    begin
      cs_sel_high = c[3];
    end
  endfunction

  // One lane per strobe; lanes share the read and write enables
  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1) begin : g_lane
      lpinit_lane u_lane (
        .clk(clk),
        .reset_n(reset_n),
        .rd_drive(rd_drive),
        .rd_byte(rd_data[8*i +: 8]),
        .wr_cap(wr_cap),
        .dqs_in(byte_lane_strobes_in[i]),
        .dq_in(dq_in[8*i +: 8]),
        .dqs_out(byte_lane_strobes_out[i]),
        .dqs_oe_n(byte_lane_strobes_oe_n[i]),
        .dq_out(dq_out[8*i +: 8]),
        .wr_byte(wr_data[8*i +: 8]),
        .wr_valid(wr_valid[i])
      );
    end
  endgenerate
endmodule

// >>> src/lpinit_regs.vh
`ifndef LPINIT_REGS_VH
`define LPINIT_REGS_VH
// Command encodings on {cs_n, ras_n, cas_n, we_n}
`define LPINIT_CMD_NOP 4'h7
`define LPINIT_CMD_PRECH 4'h2
`define LPINIT_CMD_REFR 4'h1
`define LPINIT_CMD_MRS 4'h0
// Bank select values for mode loads
`define LPINIT_BA_BASE 2'h0
`define LPINIT_BA_EXT 2'h2
// Init progress states
`define LPINIT_ST_POWER 3'h0
`define LPINIT_ST_STABLE 3'h1
`define LPINIT_ST_PRECH 3'h2
`define LPINIT_ST_READY 3'h3
// Refreshes required during init
`define LPINIT_REF_NEEDED 2'h2
// Strobe phase
`define LPINIT_PHASE_ONE 1'b1
`endif

// >>> src/lpinit_lane.v
`timescale 1ns/100ps
// One byte lane with its own strobe
module lpinit_lane (
  input wire clk,
  input wire reset_n,
  input wire rd_drive,
  input wire [7:0] rd_byte,
  input wire wr_cap,
  input wire dqs_in,
  input wire [7:0] dq_in,
  output reg dqs_out,
  output reg dqs_oe_n,
  output reg [7:0] dq_out,
  output reg [7:0] wr_byte,
  output reg wr_valid
);
  reg dqs_s1_q;
  reg dqs_s2_q;
  reg dqs_s3_q;
  reg [7:0] dq_s1_q;
  reg [7:0] dq_s2_q;
  always @(posedge clk) begin
    if (!reset_n) begin
      dqs_s1_q <= 1'b0;
      dqs_s2_q <= 1'b0;
      dqs_s3_q <= 1'b0;
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      dqs_out <= 1'b0;
      dqs_oe_n <= 1'b1;
      dq_out <= 8'h00;
      wr_byte <= 8'h00;
      wr_valid <= 1'b0;
    end else begin
      dqs_s1_q <= dqs_in;
      dqs_s2_q <= dqs_s1_q;
      dqs_s3_q <= dqs_s2_q;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      // Strobe toggles with each data beat so edges line up with data
      dqs_oe_n <= ~rd_drive;
      dq_out <= rd_byte;
      dqs_out <= rd_drive ? ~dqs_out : 1'b0;
      // Any strobe edge while wr_cap is high captures the synchronised byte
      wr_valid <= wr_cap && (dqs_s2_q != dqs_s3_q);
      if (wr_cap && (dqs_s2_q != dqs_s3_q)) begin
        wr_byte <= dq_s2_q;
      end
    end
  end
endmodule

// >>> verif/lpinit_ctl_model.sv
`timescale 1ns/100ps
`include "lpinit_regs.vh"
module lpinit_ctl_model (
  input wire clk,
  output logic mem_clk,
  output logic cke,
  output logic [3:0] cmd,
  output logic [1:0] ba,
  output logic [13:0] addr
);
  initial begin
    mem_clk = 0;
    cke = 1;
    cmd = `LPINIT_CMD_NOP;
    ba = 0;
    addr = 0;
  end
  // Free clocks with deselect on the bus; the clock runs only for these n cycles
  task automatic idle(input int n);
    cmd = 4'hf;
    repeat (n) begin
      #62.5 mem_clk = 1;
      #62.5 mem_clk = 0;
    end
  endtask
  // Clock stands still between frames; released pins show inverted junk
  task automatic issue(input [3:0] c, input [1:0] b, input [13:0] a);
    @(negedge clk);
    cmd = c;
    ba = b;
    addr = a;
    #62.5 mem_clk = 1;
    #62.5 mem_clk = 0;
    cmd = {1'b1, ~c[2:0]};
    ba = ~b;
    addr = ~a;
    #62.5;
  endtask
endmodule

// >>> verif/lpinit_top_assertions.sv
`timescale 1ns/100ps
`include "lpinit_regs.vh"
module lpinit_chk #(parameter LANES = 2, parameter MODE_W = 14) (
  input wire clk,
  input wire reset_n,
  input wire mem_clk,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bank_select,
  input wire [MODE_W-1:0] addr,
  input wire rd_drive,
  input wire [8*LANES-1:0] rd_data,
  input wire [LANES-1:0] byte_lane_strobes_out,
  input wire [LANES-1:0] byte_lane_strobes_oe_n,
  input wire [8*LANES-1:0] dq_out,
  input wire [MODE_W-1:0] base_mode_q,
  input wire [MODE_W-1:0] ext_mode_q,
  input wire ready_q,
  input wire seq_error_q,
  input wire cmd_accept_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  logic [2:0] s_q;
  logic pre_q;
  // Same three-flop view of the pin clock as the decoder
  wire rise = s_q[1] && !s_q[2];
  always @(posedge clk) begin
    s_q <= reset_n ? {s_q[1:0], mem_clk} : 3'h0;
    pre_q <= reset_n && (pre_q || (rise && cmd == `LPINIT_CMD_PRECH));
  end
  sequence s_take(c);
    rise && cmd == c;
  endsequence
  chk_accept_pulse: assert property (rise && !cs_n |=> cmd_accept_q)
    else $error("command not accepted");
  chk_deselect_mask: assert property (cmd_accept_q |-> !$past(cs_n))
    else $error("deselect accepted");
  chk_base_load: assert property (s_take(`LPINIT_CMD_MRS) ##0 pre_q &&
    bank_select == `LPINIT_BA_BASE |=> base_mode_q == $past(addr)) else $error("base load");
  chk_ext_load: assert property (s_take(`LPINIT_CMD_MRS) ##0 pre_q &&
    bank_select == `LPINIT_BA_EXT |=> ext_mode_q == $past(addr)) else $error("ext load");
  chk_early_error: assert property (s_take(`LPINIT_CMD_REFR) ##0 !pre_q |=> seq_error_q)
    else $error("early refresh passed");
  chk_ready_hold: assert property (ready_q |=> ready_q) else $error("ready dropped");
  chk_ready_cause: assert property ($rose(ready_q) |-> pre_q && $past(cmd_accept_q))
    else $error("ready without command");
  chk_strobe_enable: assert property (1 |=> byte_lane_strobes_oe_n == {LANES{!$past(rd_drive)}})
    else $error("strobe enable");
  chk_strobe_toggle: assert property ($past(rd_drive) && rd_drive |=>
    byte_lane_strobes_out == ~$past(byte_lane_strobes_out)) else $error("strobe idle");
  chk_read_bytes: assert property (rd_drive |=> dq_out == $past(rd_data))
    else $error("read bytes");
endmodule
bind lpinit_top lpinit_chk #(.LANES(LANES), .MODE_W(MODE_W)) u_chk (.clk, .reset_n, .mem_clk,
  .cs_n, .ras_n, .cas_n, .we_n, .bank_select, .addr, .rd_drive, .rd_data,
  .byte_lane_strobes_out, .byte_lane_strobes_oe_n, .dq_out, .base_mode_q, .ext_mode_q,
  .ready_q, .seq_error_q, .cmd_accept_q);

// >>> verif/lpddr_power_up_init_sequence_tb_top.sv
`timescale 1ns/100ps
`include "lpinit_regs.vh"
module lpddr_power_up_init_sequence_tb_top;
  logic clk = 0, reset_n = 0, rd_drive = 0, wr_cap = 0, mem_clk, cke, ready, err, acc;
  logic [3:0] cmd;
  logic [1:0] ba, oe_n, s_out, wr_valid, dqs = 0;
  logic [13:0] addr, b_exp, e_exp, base_q, ext_q;
  logic [15:0] rd_data = 0, dq_in = 0, dq_out, wr_data;
  int err_count = 0, checks = 0, cyc = 0, n_acc = 0, n_wv = 0;
  initial forever #2 clk = ~clk;
  lpinit_ctl_model ctl (.clk(clk), .mem_clk(mem_clk), .cke(cke), .cmd(cmd), .ba(ba), .addr(addr));
  lpinit_top #(.LANES(2), .MODE_W(14)) uut (.clk(clk), .reset_n(reset_n), .mem_clk(mem_clk),
    .cke(cke), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .bank_select(ba),
    .addr(addr), .rd_drive(rd_drive), .wr_cap(wr_cap), .rd_data(rd_data),
    .byte_lane_strobes_in(dqs), .dq_in(dq_in), .byte_lane_strobes_out(s_out),
    .byte_lane_strobes_oe_n(oe_n), .dq_out(dq_out), .wr_data(wr_data), .wr_valid(wr_valid),
    .base_mode_q(base_q), .ext_mode_q(ext_q), .ready_q(ready), .seq_error_q(err),
    .cmd_accept_q(acc));
  task automatic check(input bit ok, input string m);
    checks++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    n_acc += (acc === 1'b1);
    n_wv += (wr_valid[0] === 1'b1) + (wr_valid[1] === 1'b1);
    if (cyc == 60000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'hcc03_3073));
    repeat (16) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++) ctl.issue({1'b1, 3'($urandom)}, 2'($urandom), 14'($urandom));
    check(n_acc == 0 && base_q === 14'h0000, "deselect taken");
    b_exp = 14'($urandom);
    e_exp = 14'($urandom);
    ctl.idle((200000 + 124) / 125);
    ctl.issue(`LPINIT_CMD_PRECH, 2'h0, 14'h0400);
    ctl.issue(`LPINIT_CMD_MRS, `LPINIT_BA_EXT, e_exp);
    ctl.issue(`LPINIT_CMD_REFR, 2'h0, 14'h0000);
    ctl.issue(`LPINIT_CMD_MRS, `LPINIT_BA_BASE, b_exp);
    check(ready === 1'b0, "ready early");
    ctl.issue(`LPINIT_CMD_REFR, 2'h0, 14'h0000);
    check({ready, err, base_q, ext_q} === {2'b10, b_exp, e_exp}, "init");
    check(n_acc == 5, "accept count");
    @(posedge clk);
    rd_data <= 16'($urandom);
    rd_drive <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(oe_n === 2'b00 && dq_out === rd_data, "read drive");
    @(posedge clk);
    rd_drive <= 0;
    wr_cap <= 1;
    dq_in <= 16'($urandom);
    repeat (4) @(posedge clk);
    dqs <= 2'b11;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(oe_n === 2'b11 && wr_data === dq_in && n_wv == 2, "write");
    @(posedge clk);
    reset_n <= 0;
    wr_cap <= 0;
    repeat (16) @(posedge clk);
    reset_n <= 1;
    ctl.issue(`LPINIT_CMD_REFR, 2'h0, 14'h0000);
    check({ready, err, base_q} === {2'b01, 14'h0000}, "early refresh");
    tally_and_finish;
  end
endmodule
